/* verilog/outer_code_ctrl.sv */
// outer block code stage: mode control, interleave, framing scrambler, rate retune
`timescale 1ns/1ns
`default_nettype none
module outer_code_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire outer_code_pkg::beat_s tx_in,
  output logic tx_in_ready,
  output outer_code_pkg::beat_s tx_out,
  input wire logic tx_out_ready,
  input wire outer_code_pkg::beat_s rx_in,
  output logic rx_in_ready,
  output outer_code_pkg::beat_s rx_out,
  input wire logic rx_out_ready,
  input wire logic inner_compat_req,
  output logic aux_service_channel_en,
  output logic [31:0] chan_rate
);
  import outer_code_pkg::*;

  typedef enum logic [1:0] {TX_MSG = 2'b00, TX_PAR = 2'b01, TX_OUT = 2'b11} tx_state_e;
  typedef enum logic {RX_FILL = 1'b0, RX_OUT = 1'b1} rx_state_e;

  // ==========================================================
  // helpers
  function automatic logic [22:0] scr_byte(input logic [7:0] d, input logic [14:0] s,
                                           input logic self_sync, input logic descr);
    logic [7:0] o;
    logic [14:0] st;
    logic fb;
    o = '0;
    st = s;
    for (int i = 7; i >= 0; i--) begin
      fb = st[14] ^ st[13];
      o[i] = d[i] ^ fb;
      st = {st[13:0], self_sync ? (descr ? d[i] : o[i]) : fb};
    end
    return {st, o};
  endfunction : scr_byte

  // symbol s of codeword c lands at s*depth+c, so a linear sweep reads column-wise
  function automatic logic [MEM_AW-1:0] addr_of(input logic [7:0] s, input logic [3:0] c,
                                                input logic [3:0] d);
    logic [11:0] a;
    a = s * d + {8'h00, c};
    return a[MEM_AW-1:0];
  endfunction : addr_of

  // ==========================================================
  // registers and mode selection
  logic [31:0] ctrl;
  logic [31:0] rate;
  logic [31:0] custom;
  param_s p_308;
  param_s p_cust;
  param_s p_sel;

  wire ovr = ctrl[CTRL_OVR_BIT];
  wire mode_e sw_mode = mode_e'(ctrl[CTRL_MODE_LSB +: 2]);
  wire auto_compat = inner_compat_req & ~ovr;
  wire codec_on = ctrl[CTRL_EN_BIT] | auto_compat;
  wire mode_e eff_mode = auto_compat ? MODE_COMPAT : sw_mode;
  wire [23:0] kbps = rate[23:0];

  assign p_308 = (kbps < RATE_T1_KBPS) ? P_LOW :
                 (kbps < RATE_T2_KBPS) ? P_MID : P_HIGH;
  assign p_cust = '{n: custom[CUST_N_LSB +: 8], k: custom[CUST_K_LSB +: 8],
                    depth: custom[CUST_D_LSB +: 4]};
  wire cust_ok = p_cust.k != 8'h00 && p_cust.k <= p_cust.n &&
                 p_cust.depth != 4'h0 && p_cust.depth <= DEPTH_MAX;
  assign p_sel = (eff_mode == MODE_STD308) ? p_308 :
                 (eff_mode == MODE_COMPAT) ? P_COMPAT :
                 (eff_mode == MODE_CUSTOM && cust_ok) ? p_cust : P_HIGH;

  // n/k overhead applied to the terrestrial rate
  wire [31:0] prod = kbps * p_sel.n;
  wire [31:0] quo = prod / {24'h000000, p_sel.k};

  // ==========================================================
  // apb slave
  logic tx_idle;
  wire acc = psel & penable;
  wire wr_go = acc & pready & pwrite;
  wire hit_ctrl = paddr == OFF_CTRL;
  wire hit_rate = paddr == OFF_RATE;
  wire hit_cust = paddr == OFF_CUSTOM;
  wire hit_stat = paddr == OFF_STATUS;
  wire hit_chan = paddr == OFF_CHAN_RATE;
  wire mapped = hit_ctrl | hit_rate | hit_cust | hit_stat | hit_chan;
  wire [31:0] status_w = {9'h000, ~tx_idle, auto_compat, codec_on, p_sel.depth, p_sel.k, p_sel.n};
  wire [31:0] rd_val = hit_ctrl ? ctrl : hit_rate ? rate : hit_cust ? custom :
                       hit_stat ? status_w : hit_chan ? chan_rate : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= acc & ~pready;
      pslverr <= acc & ~pready & ~mapped;
      if (acc & ~pready) prdata <= pwrite ? 32'h00000000 : rd_val;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RESET;
      rate <= RATE_RESET;
      custom <= CUST_RESET;
    end else begin
      if (wr_go & hit_ctrl) ctrl <= pwdata & CTRL_MASK;
      if (wr_go & hit_rate) rate <= pwdata & RATE_MASK;
      if (wr_go & hit_cust) custom <= pwdata & CUST_MASK;
    end
  end

  assign aux_service_channel_en = ctrl[CTRL_AUX_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) chan_rate <= 32'h00000000;
    else chan_rate <= codec_on ? quo : {8'h00, kbps};
  end

  // ==========================================================
  // transmit: terrestrial -> scramble -> block encode -> interleave -> inner code
  tx_state_e tx_st;
  param_s tx_p;
  logic tx_on;
  logic tx_inv;
  logic [7:0] s_ix;
  logic [3:0] c_ix;
  logic [MEM_AW-1:0] rd_a;
  logic rd_pend;
  logic [14:0] tx_scr;
  logic [7:0] par_acc;
  logic [7:0] f_data;
  logic f_valid;
  logic [7:0] tx_rd;
  logic f_ready;

  stream_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .in_data(tx_in.data),
    .in_valid(tx_in.valid),
    .in_ready(tx_in_ready),
    .out_data(f_data),
    .out_valid(f_valid),
    .out_ready(f_ready)
  );

  wire out_free = ~tx_out.valid | tx_out_ready;
  assign f_ready = tx_st == TX_MSG && (tx_on || out_free);
  wire pop = f_valid & f_ready;
  assign tx_idle = tx_st == TX_MSG && s_ix == 8'h00 && c_ix == 4'h0;
  wire tx_latch = tx_idle & ~pop;
  wire [22:0] tx_sv = scr_byte(f_data, tx_scr, ~tx_on, 1'b0);
  wire [7:0] tx_byte = tx_sv[7:0] ^ {8{tx_inv}};
  wire tx_step = (pop & tx_on) | (tx_st == TX_PAR);
  wire last_msg = s_ix == tx_p.k - 8'h01;
  wire last_sym = s_ix == tx_p.n - 8'h01;
  wire last_cw = c_ix == tx_p.depth - 4'h1;
  wire tx_cw_end = tx_step & last_sym;
  wire [11:0] tx_len = tx_p.n * tx_p.depth;
  wire tx_we = tx_step;
  wire [7:0] tx_wd = (tx_st == TX_PAR) ? (par_acc ^ s_ix) : tx_byte;
  wire [MEM_AW-1:0] tx_wa = addr_of(s_ix, c_ix, tx_p.depth);
  wire rd_go = tx_st == TX_OUT && !rd_pend;
  wire tx_load = tx_st == TX_OUT && rd_pend && out_free;
  wire tx_last_rd = rd_a == tx_len[MEM_AW-1:0] - 11'h001;

  block_ram #(.AW(MEM_AW), .DW(8)) u_tx_ram (
    .pclk(pclk),
    .we(tx_we),
    .waddr(tx_wa),
    .wdata(tx_wd),
    .re(rd_go),
    .raddr(rd_a),
    .rdata(tx_rd)
  );

  // parameters are only taken between frames, so a block never mixes two sets
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_p <= P_HIGH;
      tx_on <= 1'b0;
      tx_inv <= 1'b0;
    end else if (tx_latch) begin
      tx_p <= p_sel;
      tx_on <= codec_on;
      tx_inv <= auto_compat;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st <= TX_MSG;
      s_ix <= 8'h00;
      c_ix <= 4'h0;
      par_acc <= 8'h00;
    end else begin
      if (tx_step) s_ix <= tx_cw_end ? 8'h00 : s_ix + 8'h01;
      if (tx_step & last_msg & ~last_sym) tx_st <= TX_PAR;
      if (tx_cw_end) begin
        c_ix <= last_cw ? 4'h0 : c_ix + 4'h1;
        tx_st <= last_cw ? TX_OUT : TX_MSG;
      end
      if (tx_load & tx_last_rd) tx_st <= TX_MSG;
      if (tx_cw_end) par_acc <= 8'h00;
      else if (pop & tx_on) par_acc <= {par_acc[6:0], par_acc[7]} ^ tx_byte;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) tx_scr <= SCR_SEED;
    else if (tx_cw_end || (tx_latch && codec_on != tx_on)) tx_scr <= SCR_SEED;
    else if (pop) tx_scr <= tx_sv[22:8];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_a <= '0;
      rd_pend <= 1'b0;
    end else begin
      if (rd_go) rd_pend <= 1'b1;
      else if (tx_load) rd_pend <= 1'b0;
      if (tx_load) rd_a <= tx_last_rd ? '0 : rd_a + 11'h001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) tx_out <= '{valid: 1'b0, data: 8'h00};
    else if (pop & ~tx_on) tx_out <= '{valid: 1'b1, data: tx_byte};
    else if (tx_load) tx_out <= '{valid: 1'b1, data: tx_rd};
    else if (tx_out_ready) tx_out.valid <= 1'b0;
  end

  // ==========================================================
  // receive: inner decode -> deinterleave -> strip parity -> descramble
  rx_state_e rx_st;
  param_s rx_p;
  logic rx_on;
  logic rx_inv;
  logic [MEM_AW-1:0] wa;
  logic [7:0] rs;
  logic [3:0] rc;
  logic rx_pend;
  logic [14:0] rx_scr;
  logic [7:0] rx_rd;

  wire rx_take = rx_in.valid & rx_in_ready;
  wire rx_idle = rx_st == RX_FILL && wa == '0;
  wire rx_latch = rx_idle & ~rx_take;
  wire [11:0] rx_len = rx_p.n * rx_p.depth;
  wire rx_fill_end = rx_take & rx_on & (wa == rx_len[MEM_AW-1:0] - 11'h001);
  wire rx_free = ~rx_out.valid | rx_out_ready;
  wire rx_go = rx_st == RX_OUT && !rx_pend;
  wire rx_load = rx_st == RX_OUT && rx_pend && rx_free;
  wire rx_cw_end = rx_load && rs == rx_p.k - 8'h01;
  wire rx_done = rx_cw_end && rc == rx_p.depth - 4'h1;
  wire [7:0] rx_src = rx_on ? (rx_rd ^ {8{rx_inv}}) : rx_in.data;
  wire [22:0] rx_sv = scr_byte(rx_src, rx_scr, ~rx_on, 1'b1);
  wire [MEM_AW-1:0] rx_ra = addr_of(rs, rc, rx_p.depth);
  wire next_on = rx_latch ? codec_on : rx_on;
  wire next_fill = rx_fill_end ? 1'b0 : (rx_st == RX_FILL) | rx_done;
  wire next_ov = (rx_take & ~rx_on) | rx_load | (rx_out.valid & ~rx_out_ready);

  block_ram #(.AW(MEM_AW), .DW(8)) u_rx_ram (
    .pclk(pclk),
    .we(rx_take & rx_on),
    .waddr(wa),
    .wdata(rx_in.data),
    .re(rx_go),
    .raddr(rx_ra),
    .rdata(rx_rd)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_p <= P_HIGH;
      rx_on <= 1'b0;
      rx_inv <= 1'b0;
    end else if (rx_latch) begin
      rx_p <= p_sel;
      rx_on <= codec_on;
      rx_inv <= auto_compat;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st <= RX_FILL;
      wa <= '0;
      rs <= 8'h00;
      rc <= 4'h0;
      rx_pend <= 1'b0;
      rx_in_ready <= 1'b1;
    end else begin
      if (rx_take & rx_on) wa <= rx_fill_end ? '0 : wa + 11'h001;
      if (rx_fill_end) rx_st <= RX_OUT;
      if (rx_done) rx_st <= RX_FILL;
      if (rx_go) rx_pend <= 1'b1;
      else if (rx_load) rx_pend <= 1'b0;
      if (rx_load) rs <= rx_cw_end ? 8'h00 : rs + 8'h01;
      if (rx_cw_end) rc <= rx_done ? 4'h0 : rc + 4'h1;
      rx_in_ready <= next_fill & (next_on | ~next_ov);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rx_scr <= SCR_SEED;
    else if (rx_fill_end || rx_cw_end || (rx_latch && codec_on != rx_on)) rx_scr <= SCR_SEED;
    else if ((rx_take & ~rx_on) | rx_load) rx_scr <= rx_sv[22:8];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rx_out <= '{valid: 1'b0, data: 8'h00};
    else if ((rx_take & ~rx_on) | rx_load) rx_out <= '{valid: 1'b1, data: rx_sv[7:0]};
    else if (rx_out_ready) rx_out.valid <= 1'b0;
  end

endmodule : outer_code_ctrl
`default_nettype wire

/* verilog/outer_code_pkg.sv */
// constants, types and register map for the outer block code control stage
//
// Contract
// - outer block code sits outside and in series with the inner convolutional code
// - symbols between outer and inner stages are interleaved across codewords
// - decoder gathers a complete block before processing it
// - block framing drives a frame-synchronous scrambler while outer code is active
// - standard-308 picks n,k from rate; at or above 2.048 Mbps 219,201,4
// - standard-308 below 1.544 Mbps uses 126,112,4
// - standard-308 from 1.544 to below 2.048 Mbps uses 225,205,4
// - compatibility mode uses 220,200,4, auto-selected by inner-code compat request
// - custom mode sets n, k and depth independently
// - channel rate over terrestrial rate equals n over k
// - parameter change retunes the channel-side rate automatically
// - codec enable is software controlled, independent of aux channel enable; inner_compat_req also turns it on unless the override bit is set
// - compat mode selected by inner-code setting also inverts the data
package outer_code_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_RATE = 8'h04;
  localparam logic [7:0] OFF_CUSTOM = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_CHAN_RATE = 8'h10;

  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_AUX_BIT = 1;
  localparam int CTRL_MODE_LSB = 2;
  localparam int CTRL_OVR_BIT = 4;
  localparam logic [31:0] CTRL_MASK = 32'h0000001F;
  localparam logic [31:0] CTRL_RESET = 32'h00000000;

  localparam logic [31:0] RATE_MASK = 32'h00FFFFFF;
  localparam logic [31:0] RATE_RESET = 32'h00000040;

  localparam int CUST_N_LSB = 0;
  localparam int CUST_K_LSB = 8;
  localparam int CUST_D_LSB = 16;
  localparam logic [31:0] CUST_MASK = 32'h000FFFFF;
  localparam logic [31:0] CUST_RESET = 32'h0004707E;

  // ==========================================================
  // code parameter sets
  typedef struct packed {
    logic [7:0] n;
    logic [7:0] k;
    logic [3:0] depth;
  } param_s;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } beat_s;

  typedef enum logic [1:0] {
    MODE_STD308 = 2'h0,
    MODE_STD309 = 2'h1,
    MODE_COMPAT = 2'h2,
    MODE_CUSTOM = 2'h3
  } mode_e;

  localparam logic [23:0] RATE_T1_KBPS = 24'd1544;
  localparam logic [23:0] RATE_T2_KBPS = 24'd2048;
  localparam param_s P_LOW = '{n: 8'h7E, k: 8'h70, depth: 4'h4};
  localparam param_s P_MID = '{n: 8'hE1, k: 8'hCD, depth: 4'h4};
  localparam param_s P_HIGH = '{n: 8'hDB, k: 8'hC9, depth: 4'h4};
  localparam param_s P_COMPAT = '{n: 8'hDC, k: 8'hC8, depth: 4'h4};
  localparam logic [3:0] DEPTH_MAX = 4'h8;

  // ==========================================================
  // data path sizes
  localparam int MEM_AW = 11;
  localparam int FIFO_DEPTH = 4;
  localparam logic [14:0] SCR_SEED = 15'h7FFF;

endpackage : outer_code_pkg

/* verilog/stream_fifo.sv */
// small valid/ready fifo with registered full and empty flags
`timescale 1ns/1ns
`default_nettype none
module stream_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0] cnt;

  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  wire [AW:0] next_cnt = cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  assign out_data = store[rp];

  always_ff @(posedge pclk) begin
    if (push) begin
      store[wp] <= in_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      if (push) wp <= wp + 1'b1;
      if (pop) rp <= rp + 1'b1;
      cnt <= next_cnt;
      in_ready <= next_cnt != (AW+1)'(DEPTH);
      out_valid <= next_cnt != '0;
    end
  end
endmodule : stream_fifo
`default_nettype wire

/* verilog/block_ram.sv */
// simple dual-port buffer memory with registered read data
`timescale 1ns/1ns
`default_nettype none
module block_ram #(
  parameter int AW = 11,
  parameter int DW = 8
) (
  input wire logic pclk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic re,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] cells [2**AW];

  always_ff @(posedge pclk) begin
    if (we) cells[waddr] <= wdata;
    if (re) rdata <= cells[raddr];
  end
endmodule : block_ram
`default_nettype wire

/* tb/outer_code_properties.sv */
// port assertions for the outer code control stage
`timescale 1ns/1ns
`default_nettype none
module outer_code_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire outer_code_pkg::beat_s tx_out,
  input wire logic tx_out_ready,
  input wire outer_code_pkg::beat_s rx_out,
  input wire logic rx_out_ready,
  input wire logic aux_service_channel_en,
  input wire logic [31:0] chan_rate
);
  import outer_code_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic wr_ctrl = psel && penable && pready && pwrite && paddr == OFF_CTRL;
  wire logic aux_bit = pwdata[CTRL_AUX_BIT];
  wire logic bad_addr = paddr > OFF_CHAN_RATE || paddr[1:0] != 2'h0;
  // ==========================================================
  // register bus
  apb_wait_a: assert property (psel && $rose(penable) |=> pready)
    else $error("access not answered after one wait");
  pulse_one_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  err_match_a: assert property (pready |-> pslverr == bad_addr)
    else $error("slave error does not match address");
  err_data_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returned data");
  aux_follow_a: assert property (wr_ctrl |=> aux_service_channel_en == $past(aux_bit))
    else $error("aux enable did not follow control write");
  rate_read_a: assert property (pready && !pwrite && paddr == OFF_CHAN_RATE |-> prdata == chan_rate)
    else $error("channel rate read differs from port");
  // ==========================================================
  // streams
  tx_hold_a: assert property (tx_out.valid && !tx_out_ready |=> tx_out.valid && $stable(tx_out.data))
    else $error("encoder byte dropped while stalled");
  rx_hold_a: assert property (rx_out.valid && !rx_out_ready |=> rx_out.valid && $stable(rx_out.data))
    else $error("decoded byte dropped while stalled");
  cover property (pready && pslverr);
  cover property (tx_out.valid && tx_out_ready);
  cover property (rx_out.valid && !rx_out_ready);
endmodule : outer_code_properties
bind outer_code_ctrl outer_code_properties chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .tx_out(tx_out), .tx_out_ready(tx_out_ready),
  .rx_out(rx_out), .rx_out_ready(rx_out_ready), .aux_service_channel_en(aux_service_channel_en),
  .chan_rate(chan_rate));
`default_nettype wire

/* tb/inner_loop_model.sv */
// inner codec stand-in: takes encoder bytes and loops them back to the decoder
`timescale 1ns/1ns
`default_nettype none
module inner_loop_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  input wire outer_code_pkg::beat_s tx_out,
  output logic tx_out_ready,
  output outer_code_pkg::beat_s rx_in,
  input wire logic rx_in_ready,
  output int taken
);
  import outer_code_pkg::*;
  logic [7:0] q[$];
  logic [1:0] tick;
  // series loop: encoder output feeds decoder input in order
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q.delete();
      tick <= 2'h0;
      taken <= 0;
      tx_out_ready <= 1'b0;
      rx_in <= '0;
    end else begin
      tick <= tick + 2'h1;
      tx_out_ready <= !slow || tick == 2'h0;
      if (tx_out.valid && tx_out_ready) begin
        q.push_back(tx_out.data);
        taken <= taken + 1;
      end
      if (!rx_in.valid || rx_in_ready) begin
        // idle data keeps changing so a stale byte cannot pass for a fresh one
        if (q.size() > 0 && (!slow || tick[0])) rx_in <= '{valid: 1'b1, data: q.pop_front()};
        else rx_in <= '{valid: 1'b0, data: ~rx_in.data};
      end
    end
  end
endmodule : inner_loop_model
`default_nettype wire

/* tb/outer_block_code_mode_control_bench.sv */
// self-checking bench for the outer code control stage
`timescale 1ns/1ns
`default_nettype none
module outer_block_code_mode_control_bench;
  import outer_code_pkg::*;
  typedef struct packed {
    logic [31:0] ctrl;
    logic [23:0] rate;
    logic [31:0] cust;
    param_s exp;
  } row_s;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0, compat = 1'b0, rx_out_ready = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, chan_rate, rd, ec;
  logic pready, pslverr, tx_in_ready, tx_out_ready, rx_in_ready, aux, er, on, full_seen = 1'b0;
  beat_s tx_in = '0;
  beat_s tx_out, rx_in, rx_out;
  int bad_count = 0, cmp_count = 0, cycles = 0, taken, t0, w;
  row_s rows[10] = '{
    '{32'h01, 24'h2, CUST_RESET, P_LOW}, '{32'h01, 24'h607, CUST_RESET, P_LOW},
    '{32'h01, 24'h608, CUST_RESET, P_MID}, '{32'h01, 24'h7FF, CUST_RESET, P_MID},
    '{32'h01, 24'h800, CUST_RESET, P_HIGH}, '{32'h05, 24'h40, CUST_RESET, P_HIGH},
    '{32'h09, 24'h2328, CUST_RESET, P_COMPAT}, '{32'h0D, 24'h40, 32'h000864C8, '{8'hC8, 8'h64, 4'h8}},
    '{32'h0D, 24'h40, 32'h00040080, P_HIGH}, '{32'h02, 24'hBB8, CUST_RESET, P_HIGH}};
  always #4 pclk = ~pclk;
  always @(posedge pclk) rx_out_ready <= !slow || cycles[0];
  outer_code_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_in(tx_in),
    .tx_in_ready(tx_in_ready), .tx_out(tx_out), .tx_out_ready(tx_out_ready), .rx_in(rx_in),
    .rx_in_ready(rx_in_ready), .rx_out(rx_out), .rx_out_ready(rx_out_ready), .inner_compat_req(compat),
    .aux_service_channel_en(aux), .chan_rate(chan_rate));
  inner_loop_model far (.pclk(pclk), .presetn(presetn), .slow(slow), .tx_out(tx_out),
    .tx_out_ready(tx_out_ready), .rx_in(rx_in), .rx_in_ready(rx_in_ready), .taken(taken));
  // ==========================================================
  // helpers
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic results();
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic settle(input logic [31:0] e);
    for (w = 0; w < 50 && chan_rate !== e; w++) @(posedge pclk);
  endtask : settle
  task automatic stream(input int n, input logic [7:0] s);
    int i, j;
    fork
      for (i = 0; i < n; i++) begin
        tx_in <= '{valid: 1'b1, data: s + i[7:0]};
        do begin
          @(posedge pclk);
          if (tx_in_ready === 1'b0) full_seen = 1'b1;
        end while (tx_in_ready !== 1'b1);
        if (i == n - 1) tx_in <= '0;
      end
      for (j = 0; j < n; j++) begin
        do @(posedge pclk); while ((rx_out.valid && rx_out_ready) !== 1'b1);
        chk("rx byte", {24'h0, rx_out.data}, {24'h0, s + j[7:0]});
      end
    join
  endtask : stream
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      bad_count++;
      results();
    end
  end
  // ==========================================================
  // main sequence
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[r]) begin
      on = rows[r].ctrl[0];
      ec = on ? 32'(rows[r].rate) * 32'(rows[r].exp.n) / 32'(rows[r].exp.k) : 32'(rows[r].rate);
      apb(1'b1, OFF_RATE, {8'h0, rows[r].rate});
      apb(1'b1, OFF_CUSTOM, rows[r].cust);
      apb(1'b1, OFF_CTRL, rows[r].ctrl);
      settle(ec);
      apb(1'b0, OFF_STATUS, 32'h0);
      if (on) chk("params", {12'h0, rd[19:0]}, {12'h0, rows[r].exp.depth, rows[r].exp.k, rows[r].exp.n});
      chk("codec on", {31'h0, rd[20]}, {31'h0, on});
      chk("chan rate", chan_rate, ec);
      apb(1'b0, OFF_CHAN_RATE, 32'h0);
      chk("chan rate read", rd, ec);
      chk("aux", {31'h0, aux}, {31'h0, rows[r].ctrl[1]});
    end
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, 8'h1C, 32'h1F);
    chk("unmapped err", {31'h0, er}, 32'h1);
    apb(1'b0, OFF_CTRL, 32'h0);
    chk("ctrl reset", rd, CTRL_RESET);
    apb(1'b0, OFF_RATE, 32'h0);
    chk("rate reset", rd, RATE_RESET);
    apb(1'b0, OFF_CUSTOM, 32'h0);
    chk("custom reset", rd, CUST_RESET);
    chk("off rate", chan_rate, 32'h40);
    apb(1'b0, 8'h14, 32'h0);
    chk("unmapped read", rd, 32'h0);
    compat <= 1'b1;
    settle(32'h46);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk("auto compat", {10'h0, rd[21:0]}, 32'h0034C8DC);
    apb(1'b1, OFF_CTRL, 32'h11);
    settle(32'h48);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk("override", {10'h0, rd[21:0]}, 32'h0014707E);
    compat <= 1'b0;
    apb(1'b1, OFF_CTRL, 32'h0);
    t0 = taken;
    stream(20, 8'h30);
    chk("bypass bytes", 32'(taken - t0), 32'h14);
    apb(1'b1, OFF_CTRL, 32'h1);
    slow <= 1'b1;
    t0 = taken;
    stream(448, 8'h11);
    chk("coded bytes", 32'(taken - t0), 32'h1F8);
    chk("fifo refused", {31'h0, full_seen}, 32'h1);
    results();
  end
endmodule : outer_block_code_mode_control_bench
`default_nettype wire
